// [psac_regs.svh]
/*
  constants of the address and control select block.
  assumes inclusion by bare name.
*/
`ifndef PSAC_REGS_SVH
`define PSAC_REGS_SVH

// clock rate of mclk
`define PSAC_CLK_HZ        25000000

// slave address fields, vout command code and fill byte
`define PSAC_ADDR_HI       3'h4
`define PSAC_BCAST_ADDR    7'h00
`define PSAC_ARA_ADDR      7'h0c
`define PSAC_CMD_VOUT      8'h21
`define PSAC_FILL_BYTE     8'hff

// identity inputs are millivolt samples, 13 bits wide
`define PSAC_MV_W          13
`define PSAC_UNIT_TOP_MV   13'h0bb8
`define PSAC_UNIT_STEP_MV  13'h014a
`define PSAC_UNIT_HALF_MV  13'h00a5
`define PSAC_UNIT_CODES    10

// rack selector windows, lowest and highest millivolt per code
`define PSAC_RACK1_LO      13'h0c4e
`define PSAC_RACK1_HI      13'h0d98
`define PSAC_RACK2_LO      13'h03fc
`define PSAC_RACK2_HI      13'h046a
`define PSAC_RACK3_LO      13'h0708
`define PSAC_RACK3_HI      13'h07c6
`define PSAC_RACK4_LO      13'h0226
`define PSAC_RACK4_HI      13'h0258
`define PSAC_RACK5_LO      13'h0622
`define PSAC_RACK5_HI      13'h06cc
`define PSAC_RACK6_LO      13'h0320
`define PSAC_RACK6_HI      13'h0370
`define PSAC_RACK7_LO      13'h0546
`define PSAC_RACK7_HI      13'h05d2
`define PSAC_RACK8_LO      13'h0a96
`define PSAC_RACK8_HI      13'h0bb8

// voltage program input is ignored above this level
`define PSAC_VPROG_MAX_MV  13'h0bb8

// timing figures in milliseconds
`define PSAC_START_DLY_MS  4000
`define PSAC_AUX_LEAD_MS   200
`define PSAC_WARN_LEAD_MS  10
`define PSAC_BLINK_HALF_MS 500

// reset values
`define PSAC_RST_BYTE      8'h00

`endif

// [psac_pkg.sv]
/*
  types of the address and control select block.
  assumes psac_regs.svh is reachable by bare name.
*/
package psac_pkg;

  // power sequencer states
  typedef enum logic [3:0] {
    SQ_OFF  = 4'b0001,
    SQ_WAIT = 4'b0010,
    SQ_ON   = 4'b0100,
    SQ_WARN = 4'b1000
  } psac_seq_t;

  // i2c slave states
  typedef enum logic [4:0] {
    I2_IDLE = 5'b00001,
    I2_RX   = 5'b00010,
    I2_ACK  = 5'b00100,
    I2_TX   = 5'b01000,
    I2_MACK = 5'b10000
  } psac_i2c_t;

  // source of the output set point
  typedef enum logic [2:0] {
    VS_DEFAULT = 3'b001,
    VS_PIN     = 3'b010,
    VS_FW      = 3'b100
  } psac_vsrc_t;

endpackage : psac_pkg

// [psac_i2c_slave.sv]
/*
  byte level i2c slave: own address, broadcast write and alert response.
  assumes scl and sda arrive raw from pins and are oversampled by mclk;
  sda_oe high pulls the line low.
*/
`timescale 1ns/1ns
`include "psac_regs.svh"

module psac_i2c_slave (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       nrst,
  // bus pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_oe,
  // identity and state from the control logic
  input  wire logic [3:0] own_addr,
  input  wire logic       addr_ok,
  input  wire logic       alert_pend,
  input  wire logic [7:0] rd_data,
  // events toward the control logic
  output logic            wr_stb,
  output logic            wr_first,
  output logic [7:0]      wr_data,
  output logic            ara_done,
  output logic            bcast_rd
);

  logic             scl_m_r, scl_s_r, scl_p_r;
  logic             sda_m_r, sda_s_r, sda_p_r;
  psac_pkg::psac_i2c_t st_r;
  logic [7:0]       sh_r;
  logic [7:0]       tx_r;
  logic [2:0]       bit_r;
  logic             done_r, addr_ph_r, tx_mode_r, ara_r, ara_sent_r, mack_r, first_r;
  logic             scl_rise, scl_fall, start_c, stop_c;
  logic [6:0]       own7;

  assign own7     = {`PSAC_ADDR_HI, own_addr};
  assign scl_rise = scl_s_r & ~scl_p_r;
  assign scl_fall = ~scl_s_r & scl_p_r;
  assign start_c  = scl_s_r & scl_p_r & sda_p_r & ~sda_s_r;
  assign stop_c   = scl_s_r & scl_p_r & ~sda_p_r & sda_s_r;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      {scl_m_r, scl_s_r, scl_p_r} <= 3'h7;
      {sda_m_r, sda_s_r, sda_p_r} <= 3'h7;
    end else begin
      scl_m_r <= scl_in;
      scl_s_r <= scl_m_r;
      scl_p_r <= scl_s_r;
      sda_m_r <= sda_in;
      sda_s_r <= sda_m_r;
      sda_p_r <= sda_s_r;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_r       <= psac_pkg::I2_IDLE;
      sh_r       <= `PSAC_RST_BYTE;
      tx_r       <= `PSAC_RST_BYTE;
      bit_r      <= 3'h0;
      done_r     <= 1'b0;
      addr_ph_r  <= 1'b0;
      tx_mode_r  <= 1'b0;
      ara_r      <= 1'b0;
      ara_sent_r <= 1'b0;
      mack_r     <= 1'b0;
      first_r    <= 1'b0;
      sda_oe     <= 1'b0;
      wr_stb     <= 1'b0;
      wr_first   <= 1'b0;
      wr_data    <= `PSAC_RST_BYTE;
      ara_done   <= 1'b0;
      bcast_rd   <= 1'b0;
    end else begin
      wr_stb   <= 1'b0;
      ara_done <= 1'b0;
      bcast_rd <= 1'b0;
      if (start_c) begin
        st_r      <= psac_pkg::I2_RX;
        addr_ph_r <= 1'b1;
        bit_r     <= 3'h0;
        done_r    <= 1'b0;
        sda_oe    <= 1'b0;
      end else if (stop_c) begin
        st_r   <= psac_pkg::I2_IDLE;
        sda_oe <= 1'b0;
      end else begin
        unique case (st_r)
          psac_pkg::I2_IDLE: begin
            sda_oe <= 1'b0;
          end
          psac_pkg::I2_RX: begin
            if (scl_rise) begin
              sh_r   <= {sh_r[6:0], sda_s_r};
              bit_r  <= bit_r + 3'h1;
              done_r <= (bit_r == 3'h7);
            end else if (scl_fall && done_r) begin
              done_r <= 1'b0;
              if (addr_ph_r) begin
                addr_ph_r  <= 1'b0;
                first_r    <= 1'b1;
                ara_r      <= 1'b0;
                ara_sent_r <= 1'b0;
                if (!addr_ok) begin
                  st_r <= psac_pkg::I2_IDLE;
                  bcast_rd <= (sh_r == {`PSAC_BCAST_ADDR, 1'b1});
                end else if (sh_r[7:1] == own7) begin
                  sda_oe    <= 1'b1;
                  tx_mode_r <= sh_r[0];
                  st_r      <= psac_pkg::I2_ACK;
                end else if (sh_r == {`PSAC_BCAST_ADDR, 1'b0}) begin
                  sda_oe    <= 1'b1;
                  tx_mode_r <= 1'b0;
                  st_r      <= psac_pkg::I2_ACK;
                end else if (sh_r == {`PSAC_BCAST_ADDR, 1'b1}) begin
                  bcast_rd <= 1'b1;
                  st_r     <= psac_pkg::I2_IDLE;
                end else if (sh_r == {`PSAC_ARA_ADDR, 1'b1} && alert_pend) begin
                  sda_oe    <= 1'b1;
                  tx_mode_r <= 1'b1;
                  ara_r     <= 1'b1;
                  st_r      <= psac_pkg::I2_ACK;
                end else begin
                  st_r <= psac_pkg::I2_IDLE;
                end
              end else begin
                sda_oe   <= 1'b1;
                wr_stb   <= 1'b1;
                wr_first <= first_r;
                wr_data  <= sh_r;
                first_r  <= 1'b0;
                st_r     <= psac_pkg::I2_ACK;
              end
            end
          end
          psac_pkg::I2_ACK, psac_pkg::I2_MACK: begin
            if (scl_rise) begin
              mack_r <= ~sda_s_r;
            end else if (scl_fall) begin
              bit_r  <= 3'h0;
              done_r <= 1'b0;
              if (st_r == psac_pkg::I2_MACK && !mack_r) begin
                sda_oe <= 1'b0;
                st_r   <= psac_pkg::I2_IDLE;
              end else if (tx_mode_r) begin
                // reply carries the 7-bit address in the upper bits
                tx_r   <= (ara_r && !ara_sent_r) ? {own7, 1'b1} :
                          (ara_r ? `PSAC_FILL_BYTE : rd_data);
                sda_oe <= (ara_r && !ara_sent_r) ? ~own7[6] :
                          (ara_r ? 1'b0 : ~rd_data[7]);
                st_r   <= psac_pkg::I2_TX;
              end else begin
                sda_oe <= 1'b0;
                st_r   <= psac_pkg::I2_RX;
              end
            end
          end
          psac_pkg::I2_TX: begin
            if (scl_rise) begin
              bit_r  <= bit_r + 3'h1;
              done_r <= (bit_r == 3'h7);
              // a lower address from another unit wins the wired bus
              if (!sda_oe && !sda_s_r) begin
                st_r <= psac_pkg::I2_IDLE;
              end
            end else if (scl_fall) begin
              if (done_r) begin
                done_r <= 1'b0;
                sda_oe <= 1'b0;
                st_r   <= psac_pkg::I2_MACK;
                if (ara_r && !ara_sent_r) begin
                  ara_sent_r <= 1'b1;
                  ara_done   <= 1'b1;
                end
              end else begin
                sda_oe <= ~tx_r[6];
                tx_r   <= {tx_r[6:0], 1'b1};
              end
            end
          end
        endcase
      end
    end
  end

endmodule : psac_i2c_slave

// [psac_top.sv]
/*
  address and control select: identity decode, i2c address, set point,
  sequencing and input led.
  assumes millivolt samples and monitor levels asynchronous to mclk.
*/
// Notes on behaviour
// - address byte is 100 plus four bits
// - byte lsb: 0 write, 1 read
// - sixteen units share one bus
// - address bits come from unit and rack inputs
// - first arrangement: rack 1-4 and 6-8
// - second arrangement: unit 6-7 and 8-10
// - unit input: ten levels, 5 V invalid
// - rack input: eight codes, five percent windows
// - firmware voltage command overrides pin until reset
// - pin above 3 V means default set point
// - strap at secondary return selects i2c mode
// - i2c mode waits over four seconds to start
// - warning leads main output loss 5-20 ms
// - aux output leads main by 200 ms outside i2c mode, by the start delay in i2c mode
// - input led blinks while input is low
// - broadcast read flags invalid command
// - alert response returns own address
// - alert released only when own address won
`timescale 1ns/1ns
`include "psac_regs.svh"

module psac_top #(
  parameter int unsigned START_DLY_CYC = `PSAC_START_DLY_MS * (`PSAC_CLK_HZ / 1000) + 1,
  parameter int unsigned AUX_LEAD_CYC  = `PSAC_AUX_LEAD_MS * (`PSAC_CLK_HZ / 1000),
  parameter int unsigned WARN_LEAD_CYC = `PSAC_WARN_LEAD_MS * (`PSAC_CLK_HZ / 1000),
  parameter int unsigned BLINK_CYC     = `PSAC_BLINK_HALF_MS * (`PSAC_CLK_HZ / 1000)
) (
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  nrst,
  // identity and strap inputs
  input  wire logic [`PSAC_MV_W-1:0] unit_position_select,
  input  wire logic [`PSAC_MV_W-1:0] rack_position_select,
  input  wire logic                  slot_strap_input,
  // voltage program and input monitors
  input  wire logic [`PSAC_MV_W-1:0] vprog_mv,
  input  wire logic                  input_ok,
  input  wire logic                  input_below_80v,
  // alert and command flags
  input  wire logic                  alert_req,
  input  wire logic                  invalid_cmd_clr,
  // i2c pins
  input  wire logic                  scl_in,
  input  wire logic                  sda_in,
  output logic                       sda_oe,
  output logic                       alert_n_oe,
  // identity and set point results
  output logic [3:0]                 configured_address,
  output logic                       address_fault,
  output logic                       i2c_mode,
  output logic [2:0]                 setpoint_source,
  output logic [`PSAC_MV_W-1:0]      setpoint_pin_mv,
  output logic [7:0]                 setpoint_fw,
  output logic                       invalid_cmd,
  // power sequencing and indicator
  output logic                       aux_standby_output,
  output logic                       main_output_enable,
  output logic                       power_good_warning,
  output logic                       input_led_on
);

  logic [`PSAC_MV_W-1:0] unit_m_r, unit_s_r, rack_m_r, rack_s_r, vp_m_r, vp_s_r;
  logic [3:0]            mon_m_r, mon_s_r;
  logic [3:0]            unit_code, rack_code, addr_nxt;
  logic                  addr_ok_nxt, fw_set_r, vout_armed_r, alert_pend_r;
  logic                  wr_stb, wr_first, ara_done, bcast_rd;
  logic [7:0]            wr_data;
  logic [31:0]           seq_cnt_r, blink_cnt_r;
  psac_pkg::psac_seq_t   seq_r;

  // identity levels are straps, so a torn sample settles within two cycles
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      {unit_m_r, unit_s_r, rack_m_r, rack_s_r} <= '0;
      vp_m_r  <= '1;
      vp_s_r  <= '1;
      mon_m_r <= 4'h1;
      mon_s_r <= 4'h1;
    end else begin
      unit_m_r <= unit_position_select;
      unit_s_r <= unit_m_r;
      rack_m_r <= rack_position_select;
      rack_s_r <= rack_m_r;
      vp_m_r   <= vprog_mv;
      vp_s_r   <= vp_m_r;
      mon_m_r  <= {input_below_80v, input_ok, 1'b0, slot_strap_input};
      mon_s_r  <= mon_m_r;
    end
  end

  // unit code 1..10 from evenly stepped levels, 0 for invalid
  function automatic logic [3:0] unit_q(input logic [`PSAC_MV_W-1:0] mv);
    logic [`PSAC_MV_W-1:0] nom;
    unit_q = 4'h0;
    nom    = `PSAC_UNIT_TOP_MV;
    for (int i = 1; i <= `PSAC_UNIT_CODES; i++) begin
      if (mv + `PSAC_UNIT_HALF_MV >= nom && mv <= nom + `PSAC_UNIT_HALF_MV) begin
        unit_q = 4'(i);
      end
      nom = nom - `PSAC_UNIT_STEP_MV;
    end
  endfunction : unit_q

  function automatic logic [3:0] rack_q(input logic [`PSAC_MV_W-1:0] mv);
    rack_q = 4'h0;
    if (mv >= `PSAC_RACK1_LO && mv <= `PSAC_RACK1_HI) rack_q = 4'h1;
    if (mv >= `PSAC_RACK2_LO && mv <= `PSAC_RACK2_HI) rack_q = 4'h2;
    if (mv >= `PSAC_RACK3_LO && mv <= `PSAC_RACK3_HI) rack_q = 4'h3;
    if (mv >= `PSAC_RACK4_LO && mv <= `PSAC_RACK4_HI) rack_q = 4'h4;
    if (mv >= `PSAC_RACK5_LO && mv <= `PSAC_RACK5_HI) rack_q = 4'h5;
    if (mv >= `PSAC_RACK6_LO && mv <= `PSAC_RACK6_HI) rack_q = 4'h6;
    if (mv >= `PSAC_RACK7_LO && mv <= `PSAC_RACK7_HI) rack_q = 4'h7;
    if (mv >= `PSAC_RACK8_LO && mv <= `PSAC_RACK8_HI) rack_q = 4'h8;
  endfunction : rack_q

  assign unit_code = unit_q(unit_s_r);
  assign rack_code = rack_q(rack_s_r);

  always_comb begin
    addr_nxt    = 4'h0;
    addr_ok_nxt = 1'b1;
    if (unit_code == 4'h0 || rack_code == 4'h0) begin
      addr_ok_nxt = 1'b0;
    end else if (rack_code <= 4'h4 && unit_code <= 4'h4) begin
      addr_nxt = 4'((rack_code - 4'h1) * 4'h4 + unit_code - 4'h1);
    end else if (rack_code >= 4'h6 && unit_code <= 4'h5) begin
      addr_nxt = 4'((rack_code - 4'h6) * 4'h5 + unit_code - 4'h1);
    end else if (unit_code == 4'h6 || unit_code == 4'h7) begin
      addr_nxt = 4'((rack_code - 4'h1) * 4'h2 + unit_code - 4'h6);
    end else if (unit_code >= 4'h8 && rack_code >= 4'h4) begin
      addr_nxt = 4'((rack_code - 4'h4) * 4'h3 + unit_code - 4'h8);
    end else begin
      addr_ok_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      configured_address <= 4'h0;
      address_fault      <= 1'b1;
      i2c_mode           <= 1'b0;
    end else begin
      configured_address <= addr_nxt;
      address_fault      <= ~addr_ok_nxt;
      i2c_mode           <= ~mon_s_r[0];
    end
  end

  // set point source; only a reset of the controller brings the pin back
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      fw_set_r        <= 1'b0;
      vout_armed_r    <= 1'b0;
      setpoint_fw     <= `PSAC_RST_BYTE;
      setpoint_pin_mv <= '0;
      setpoint_source <= psac_pkg::VS_DEFAULT;
    end else begin
      if (wr_stb) begin
        vout_armed_r <= wr_first && (wr_data == `PSAC_CMD_VOUT);
        if (!wr_first && vout_armed_r) begin
          setpoint_fw  <= wr_data;
          fw_set_r     <= 1'b1;
          vout_armed_r <= 1'b0;
        end
      end
      setpoint_pin_mv <= vp_s_r;
      if (fw_set_r) begin
        setpoint_source <= psac_pkg::VS_FW;
      end else if (vp_s_r > `PSAC_VPROG_MAX_MV) begin
        setpoint_source <= psac_pkg::VS_DEFAULT;
      end else begin
        setpoint_source <= psac_pkg::VS_PIN;
      end
    end
  end

  // set wins over clear for both flags
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      invalid_cmd  <= 1'b0;
      alert_pend_r <= 1'b0;
    end else begin
      invalid_cmd  <= bcast_rd | (invalid_cmd & ~invalid_cmd_clr);
      alert_pend_r <= alert_req | (alert_pend_r & ~ara_done);
    end
  end

  assign alert_n_oe = alert_pend_r;

  psac_i2c_slave u_slave (
    .mclk       (mclk),
    .nrst       (nrst),
    .scl_in     (scl_in),
    .sda_in     (sda_in),
    .sda_oe     (sda_oe),
    .own_addr   (configured_address),
    .addr_ok    (~address_fault & i2c_mode),
    .alert_pend (alert_pend_r),
    .rd_data    ({fw_set_r, setpoint_source, main_output_enable, power_good_warning,
                  invalid_cmd, alert_pend_r}),
    .wr_stb     (wr_stb),
    .wr_first   (wr_first),
    .wr_data    (wr_data),
    .ara_done   (ara_done),
    .bcast_rd   (bcast_rd)
  );

  // the start delay also covers the aux lead, so aux always comes first
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      seq_r              <= psac_pkg::SQ_OFF;
      seq_cnt_r          <= '0;
      aux_standby_output <= 1'b0;
      main_output_enable <= 1'b0;
      power_good_warning <= 1'b0;
    end else begin
      seq_cnt_r <= seq_cnt_r + 32'h1;
      unique case (seq_r)
        psac_pkg::SQ_OFF: begin
          main_output_enable <= 1'b0;
          power_good_warning <= 1'b0;
          aux_standby_output <= mon_s_r[2];
          if (mon_s_r[2]) begin
            seq_r     <= psac_pkg::SQ_WAIT;
            seq_cnt_r <= '0;
          end
        end
        psac_pkg::SQ_WAIT: begin
          if (!mon_s_r[2]) begin
            seq_r              <= psac_pkg::SQ_OFF;
            aux_standby_output <= 1'b0;
          end else if (seq_cnt_r >= (i2c_mode ? START_DLY_CYC : AUX_LEAD_CYC) - 1) begin
            seq_r              <= psac_pkg::SQ_ON;
            main_output_enable <= 1'b1;
          end
        end
        psac_pkg::SQ_ON: begin
          if (!mon_s_r[2]) begin
            seq_r              <= psac_pkg::SQ_WARN;
            seq_cnt_r          <= '0;
            power_good_warning <= 1'b1;
          end
        end
        psac_pkg::SQ_WARN: begin
          if (seq_cnt_r >= WARN_LEAD_CYC - 1) begin
            seq_r              <= psac_pkg::SQ_OFF;
            main_output_enable <= 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      blink_cnt_r  <= '0;
      input_led_on <= 1'b0;
    end else if (mon_s_r[3]) begin
      blink_cnt_r <= (blink_cnt_r >= BLINK_CYC - 1) ? '0 : blink_cnt_r + 32'h1;
      if (blink_cnt_r >= BLINK_CYC - 1) begin
        input_led_on <= ~input_led_on;
      end
    end else begin
      blink_cnt_r  <= '0;
      input_led_on <= 1'b1;
    end
  end

endmodule : psac_top

// [psac_top_chk.sv]
/* checker of psac_top ports; assumes the bind passes the timing parameters. */
`timescale 1ns/1ns
`include "psac_regs.svh"
module psac_top_chk #(
  parameter int unsigned START_DLY_CYC = 40,
  parameter int unsigned AUX_LEAD_CYC  = 10,
  parameter int unsigned WARN_LEAD_CYC = 5
) (
  input wire logic                  mclk,
  input wire logic                  nrst,
  input wire logic [`PSAC_MV_W-1:0] vprog_mv,
  input wire logic                  slot_strap_input,
  input wire logic                  alert_req,
  input wire logic                  invalid_cmd_clr,
  input wire logic                  sda_oe,
  input wire logic                  alert_n_oe,
  input wire logic                  address_fault,
  input wire logic                  i2c_mode,
  input wire logic [2:0]            setpoint_source,
  input wire logic                  invalid_cmd,
  input wire logic                  aux_standby_output,
  input wire logic                  main_output_enable,
  input wire logic                  power_good_warning
);
  int unsigned aux_cnt;
  int unsigned warn_cnt;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) aux_cnt <= 0;
    else aux_cnt <= aux_standby_output ? aux_cnt + 1 : 0;
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) warn_cnt <= 0;
    else warn_cnt <= power_good_warning ? warn_cnt + 1 : 0;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence s_main_up; $rose(main_output_enable); endsequence
  sequence s_main_down; $fell(main_output_enable); endsequence
  AST_ALERT_SET: assert property (alert_req |=> alert_n_oe)
    else $error("alert not set");
  AST_MODE: assert property (!slot_strap_input [*5] |-> i2c_mode)
    else $error("mode not i2c");
  AST_NO_ACK: assert property (address_fault [*8] |-> !sda_oe)
    else $error("ack while faulted");
  AST_FW_STICKY: assert property (setpoint_source == 3'h4 |=> setpoint_source == 3'h4)
    else $error("fw source lost");
  AST_DEFAULT: assert property ((vprog_mv > 13'h0bb8) [*5] |-> setpoint_source != 3'h2)
    else $error("pin source above 3 V");
  AST_INV_HOLD: assert property (invalid_cmd && !invalid_cmd_clr |=> invalid_cmd)
    else $error("invalid flag lost");
  AST_AUX_LEAD: assert property (s_main_up |-> aux_cnt >= AUX_LEAD_CYC - 1)
    else $error("aux lead short");
  AST_START_DLY: assert property (s_main_up ##0 i2c_mode |-> aux_cnt >= START_DLY_CYC - 1)
    else $error("start delay short");
  AST_WARN_LEAD: assert property (s_main_down |->
    warn_cnt >= WARN_LEAD_CYC / 2 && warn_cnt <= 2 * WARN_LEAD_CYC)
    else $error("warning lead off");
endmodule : psac_top_chk
bind psac_top psac_top_chk #(.START_DLY_CYC(START_DLY_CYC), .AUX_LEAD_CYC(AUX_LEAD_CYC),
  .WARN_LEAD_CYC(WARN_LEAD_CYC)) u_chk (.mclk(mclk), .nrst(nrst), .vprog_mv(vprog_mv),
  .slot_strap_input(slot_strap_input), .alert_req(alert_req),
  .invalid_cmd_clr(invalid_cmd_clr), .sda_oe(sda_oe), .alert_n_oe(alert_n_oe),
  .address_fault(address_fault), .i2c_mode(i2c_mode), .setpoint_source(setpoint_source),
  .invalid_cmd(invalid_cmd), .aux_standby_output(aux_standby_output),
  .main_output_enable(main_output_enable), .power_good_warning(power_good_warning));

// [psac_host.sv]
/* i2c host model, msb first; assumes the bench resolves the pulled-up sda wire. */
`timescale 1ns/1ns
module psac_host (
  // clock and bus
  input  wire logic mclk,
  input  wire logic sda,
  output logic      scl = 1'b1,
  output logic      sda_low = 1'b0
);
  task automatic half;
    repeat (8) @(posedge mclk);
    #1;
  endtask : half
  task automatic start;
    sda_low = 1'b1;
    half();
    scl = 1'b0;
    half();
  endtask : start
  task automatic stop;
    sda_low = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b0;
    half();
  endtask : stop
  // lsb of an address byte is the direction the caller chose
  task automatic xbyte(input logic [7:0] tx, input logic mack,
                       output logic [7:0] rx, output logic ack);
    logic [8:0] bits;
    logic [8:0] seen;
    bits = {tx, mack};
    for (int i = 8; i >= 0; i--) begin
      // data moves well after the clock fell so no false start is seen
      repeat (2) @(posedge mclk);
      #1 sda_low = !bits[i];
      half();
      scl = 1'b1;
      half();
      seen[i] = sda;
      scl = 1'b0;
    end
    rx = seen[8:1];
    ack = !seen[0];
  endtask : xbyte
endmodule : psac_host

// [testbench.sv]
/* bench of psac_top and the i2c host model; assumes the host and checker compile with it. */
`timescale 1ns/1ns
module testbench;
  logic        mclk, nrst, strap, in_ok, below80, alert_req, inv_clr, ack, prev;
  logic        scl, h_low, sda_oe, alert_oe, fault, i2c_mode, inv, aux, main_en, warn, led;
  logic [12:0] unit_mv, rack_mv, vprog, pin_mv;
  logic [3:0]  addr;
  logic [2:0]  src;
  logic [7:0]  fw, rx, b;
  wire         sda = !(sda_oe || h_low);
  int          err_total, n_tests, n, d;
  int unsigned rack_nom [8] = '{3310, 1070, 1890, 580, 1660, 840, 1420, 2860};
  psac_top #(.START_DLY_CYC(40), .AUX_LEAD_CYC(10), .WARN_LEAD_CYC(5), .BLINK_CYC(8)) u_dut (
    .mclk(mclk), .nrst(nrst), .unit_position_select(unit_mv), .rack_position_select(rack_mv),
    .slot_strap_input(strap), .vprog_mv(vprog), .input_ok(in_ok), .input_below_80v(below80),
    .alert_req(alert_req), .invalid_cmd_clr(inv_clr), .scl_in(scl), .sda_in(sda),
    .sda_oe(sda_oe), .alert_n_oe(alert_oe), .configured_address(addr), .address_fault(fault),
    .i2c_mode(i2c_mode), .setpoint_source(src), .setpoint_pin_mv(pin_mv), .setpoint_fw(fw),
    .invalid_cmd(inv), .aux_standby_output(aux), .main_output_enable(main_en),
    .power_good_warning(warn), .input_led_on(led));
  psac_host u_host (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(h_low));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask : tick
  task automatic xb(input logic [7:0] tx, input logic mack);
    u_host.xbyte(tx, mack, rx, ack);
  endtask : xb
  function automatic logic [4:0] exp_id(input int u, input int r);
    if (u >= 1 && u <= 4 && r <= 4) return {1'b0, 4'((r - 1) * 4 + u - 1)};
    if (u >= 1 && u <= 5 && r >= 6) return {1'b0, 4'((r - 6) * 5 + u - 1)};
    if (u == 6 || u == 7) return {1'b0, 4'((r - 1) * 2 + u - 6)};
    if (u >= 8 && r >= 4) return {1'b0, 4'((r - 4) * 3 + u - 8)};
    return 5'h10;
  endfunction : exp_id
  // unit code 0 stands for the invalid five volt level
  task automatic set_id(input int u, input int r);
    unit_mv = (u == 0) ? 13'h1388 : 13'(3000 - 330 * (u - 1) + $urandom_range(20) - 10);
    rack_mv = 13'(rack_nom[r - 1] + $urandom_range(10) - 5);
    tick(8);
  endtask : set_id
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    repeat (60000) @(posedge mclk);
    err_total++;
    stop_test();
  end
  initial begin
    {nrst, strap, in_ok, below80, alert_req, inv_clr} = '0;
    {unit_mv, rack_mv, vprog} = {13'h0000, 13'h0000, 13'h1388};
    err_total = 0;
    n_tests = 0;
    void'($urandom(60737));
    tick(6);
    nrst = 1'b1;
    for (int u = 0; u <= 10; u++) begin
      for (int r = 1; r <= 8; r++) begin
        set_id(u, r);
        chk({fault, fault ? 4'h0 : addr}, exp_id(u, r));
      end
    end
    $display("test identity done");
    set_id(2, 3);
    chk(i2c_mode, 1'b1);
    for (int a = 0; a < 16; a++) begin
      u_host.start();
      xb(8'h80 | 8'(a << 1), 1'b1);
      u_host.stop();
      chk(ack, 5'(a) == exp_id(2, 3));
    end
    $display("test address done");
    vprog = 13'h05dc;
    tick(6);
    chk({src, pin_mv}, {3'h2, 13'h05dc});
    vprog = 13'h0c1c;
    tick(6);
    chk(src, 3'h1);
    b = 8'($urandom);
    u_host.start();
    xb(8'h00, 1'b1);
    xb(8'h21, 1'b1);
    xb(b, 1'b1);
    u_host.stop();
    vprog = 13'h05dc;
    tick(6);
    chk({ack, src, fw}, {1'b1, 3'h4, b});
    u_host.start();
    xb(8'h93, 1'b1);
    xb(8'hff, 1'b1);
    u_host.stop();
    chk(rx[6:4], 3'h4);
    $display("test set point done");
    u_host.start();
    xb(8'h01, 1'b1);
    u_host.stop();
    chk({ack, inv}, 2'b01);
    inv_clr = 1'b1;
    tick(1);
    inv_clr = 1'b0;
    tick(2);
    chk(inv, 1'b0);
    set_id(0, 1);
    u_host.start();
    xb(8'h92, 1'b1);
    u_host.stop();
    chk(ack, 1'b0);
    set_id(2, 3);
    u_host.start();
    xb(8'h19, 1'b1);
    u_host.stop();
    chk(ack, 1'b0);
    alert_req = 1'b1;
    tick(1);
    alert_req = 1'b0;
    chk(alert_oe, 1'b1);
    u_host.start();
    xb(8'h19, 1'b1);
    chk(ack, 1'b1);
    xb(8'hff, 1'b1);
    u_host.stop();
    chk({rx, alert_oe}, {3'b100, 4'(exp_id(2, 3)), 1'b1, 1'b0});
    $display("test bus flags done");
    for (int s = 1; s >= 0; s--) begin
      strap = 1'(s);
      d = s ? 10 : 40;
      tick(6);
      in_ok = 1'b1;
      for (n = 0; !aux && n < 20; n++) tick(1);
      for (n = 0; !main_en && n < 100; n++) tick(1);
      chk({aux, n >= d - 1 && n <= d + 3}, 2'b11);
      in_ok = 1'b0;
      for (n = 0; !warn && n < 20; n++) tick(1);
      for (n = 0; main_en && n < 50; n++) tick(1);
      chk({warn, n >= 2 && n <= 10}, 2'b11);
    end
    $display("test sequencing done");
    below80 = 1'b1;
    tick(6);
    prev = led;
    d = 0;
    repeat (40) begin
      tick(1);
      if (led !== prev) d++;
      prev = led;
    end
    chk(d >= 4 && d <= 5, 1'b1);
    $display("test led done");
    stop_test();
  end
endmodule : testbench
